// >>> irk_bit_rx.sv
`timescale 1ns/10ps

module irk_bit_rx #(
   parameter bit INV_INPUT = 1'b0
) (
   input wire logic clk,                    // system clock
   input wire logic arst_n,                 // async reset, active low
   input wire logic tick,                   // time base enable
   input wire logic irSerialInput,          // demodulated receiver pin
   output irk_pkg::irk_sym_s sym            // decoded bit or abort
);

   typedef struct packed {
      logic sync1;
      logic sync2;
      logic [7:0] markCnt;
      logic [7:0] idleCnt;
      logic idleDone;
      irk_pkg::irk_sym_s sym;
   } irk_rx_s;

   irk_rx_s q;
   irk_rx_s d;
   logic mark;

   // ==========================================================================
   // mark width decode
   always_comb
   begin
      d = q;
      d.sym = '0;
      d.sync1 = irSerialInput;
      d.sync2 = q.sync1;
      mark = q.sync2 ^ INV_INPUT;
      if (mark)
      begin
         d.idleCnt = '0;
         d.idleDone = 1'b0;
         if (tick && q.markCnt != 8'hff)
         begin
            d.markCnt = q.markCnt + 8'h01;
         end
      end
      else
      begin
         // marks shorter than the glitch floor are noise, not bits
         if (q.markCnt >= irk_pkg::GLITCH_TICKS)
         begin
            d.sym.valid = 1'b1;
            d.sym.value = (q.markCnt >= irk_pkg::ONE_MIN_TICKS);
         end
         d.markCnt = '0;
         if (tick && !q.idleDone)
         begin
            if (q.idleCnt == irk_pkg::GAP_LAST)
            begin
               d.sym.abort = 1'b1;
               d.idleDone = 1'b1;
            end
            else
            begin
               d.idleCnt = q.idleCnt + 8'h01;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         q <= '{sync1: INV_INPUT, sync2: INV_INPUT, idleDone: 1'b1,
                default: '0};
      end
      else
      begin
         q <= d;
      end
   end

   assign sym = q.sym;

endmodule

// >>> irk_ir_tx.sv
`timescale 1ns/10ps

module irk_ir_tx #(
   parameter int TICK_CYC = irk_pkg::TICK_CYC
) (
   input wire logic clk, // bench clock
   output logic line // demodulated line, high is mark
);
   initial line = 1'b0;

   task automatic level(input logic m, input int ticks);
      line <= m;
      repeat (ticks * TICK_CYC) @(negedge clk);
   endtask

   // sent first bit first: code, group, keys 1..6
   task automatic send_frame(input logic [11:0] f);
      for (int i = 11; i >= 0; i--)
      begin
         level(1'b1, f[i] ? 70 : 5);
         level(1'b0, 5);
      end
      level(1'b0, 30);
   endtask

   task automatic send_pair(input logic [11:0] f);
      send_frame(f);
      send_frame(f);
   endtask
endmodule

// >>> irk_key_decoder.sv
`timescale 1ns/10ps

module irk_key_decoder #(
   parameter bit PINS24 = 1'b1,
   parameter bit INV_INPUT = 1'b0,
   parameter bit DEP_TOGGLE = 1'b0,
   parameter int TICK_CYC = irk_pkg::TICK_CYC
) (
   input wire logic clk,                    // 100 MHz system clock
   input wire logic arst_n,                 // async reset, active low
   input wire logic irSerialInput,          // demodulated receiver pin
   input wire logic matchStrapA,            // code strap, 24-pin only
   input wire logic matchStrapB,            // code strap, both variants
   input wire logic matchStrapC,            // code strap, 16-pin only
   output irk_pkg::irk_keys_s keys,         // held, pulse and toggle outputs
   output logic dataLatch,                  // one-cycle data match latch
   output logic [8:0] latchedData           // group and key bits last latched
);

   // ==========================================================================
   // build checks
   if (irk_pkg::SHIFT_BITS + 2 != irk_pkg::FRAME_BITS)
   begin : g_chk_frame
      $error("frame and shift register lengths do not fit the overflow path");
   end
   if (irk_pkg::CODE_BITS + irk_pkg::DATA_BITS != irk_pkg::FRAME_BITS)
   begin : g_chk_fields
      $error("code and data fields do not fill the frame");
   end
   if (TICK_CYC < 1 || TICK_CYC > 1024)
   begin : g_chk_tick
      $error("time base divider does not fit its 10-bit counter");
   end

   // clocks per 10 us tick; a short divider only speeds up simulation
   localparam logic [9:0] TICK_END = 10'(TICK_CYC - 1);

   typedef struct packed {
      irk_pkg::irk_frame_e state;
      logic [3:0] bitCnt;
      logic [9:0] shreg;
      logic [1:0] ovf;
      logic mismatch;
      logic [7:0] gapMs;
      logic [9:0] tickCnt;
      logic [6:0] subMs;
      logic [2:0] strap1;
      logic [2:0] strap2;
      logic [8:0] data;
      logic latch;
      logic [irk_pkg::N_HELD-1:0][7:0] holdCnt;
      logic [irk_pkg::N_PULSE-1:0][7:0] pulseCnt;
      irk_pkg::irk_keys_s keys;
   } irk_main_s;

   irk_main_s q;
   irk_main_s d;
   irk_pkg::irk_sym_s sym;
   logic tick;
   logic msTick;
   logic [2:0] expCode;
   logic [2:0] rxCode;
   logic fullMismatch;
   logic [8:0] payload;
   logic [5:0] keyBits;
   logic [irk_pkg::N_HELD-1:0] heldMask;
   logic [irk_pkg::N_PULSE-1:0] pulseMask;
   logic [irk_pkg::N_HELD-1:0] heldHit;
   logic [irk_pkg::N_PULSE-1:0] pulseHit;
   logic [irk_pkg::N_FLIP-1:0] flipHit;
   logic [irk_pkg::N_FLIP-1:0] flipNext;

   // ==========================================================================
   // bit symbol receiver
   irk_bit_rx #(
      .INV_INPUT(INV_INPUT)
   ) u_bit_rx (
      .clk(clk),
      .arst_n(arst_n),
      .tick(tick),
      .irSerialInput(irSerialInput),
      .sym(sym)
   );

   // ==========================================================================
   // time base and strap code
   always_comb
   begin
      tick = (q.tickCnt == TICK_END);
      msTick = tick && (q.subMs == irk_pkg::MS_LAST);
      // straps are pulled up inside, so an open pin reads one
      if (PINS24)
      begin
         expCode = {q.strap2[2], q.strap2[1], 1'b1};
      end
      else
      begin
         expCode = {1'b1, q.strap2[1], q.strap2[0]};
      end
      heldMask = PINS24 ? '1 : irk_pkg::HELD_MASK16;
      pulseMask = PINS24 ? '1 : irk_pkg::PULSE_MASK16;
      keyBits = q.data[irk_pkg::KEY_FIRST_POS -: 6];
   end

   // ==========================================================================
   // class decode of the latched data
   always_comb
   begin
      heldHit = '0;
      pulseHit = '0;
      flipHit = '0;
      for (int k = 0; k < irk_pkg::N_HELD; k++)
      begin
         heldHit[k] = q.latch && q.data[irk_pkg::GRP_FIRST_POS] &&
                      keyBits[5-k] && heldMask[k];
         pulseHit[k] = q.latch && q.data[irk_pkg::GRP_SECOND_POS] &&
                       keyBits[5-k] && pulseMask[k];
      end
      for (int k = 0; k < irk_pkg::PULSE_GRP3_KEYS; k++)
      begin
         pulseHit[irk_pkg::PULSE_GRP3_BASE+k] =
            q.latch && q.data[irk_pkg::GRP_THIRD_POS] && keyBits[5-k] &&
            pulseMask[irk_pkg::PULSE_GRP3_BASE+k];
      end
      for (int k = 0; k < irk_pkg::N_FLIP; k++)
      begin
         flipHit[k] = q.latch && q.data[irk_pkg::GRP_THIRD_POS] &&
                      keyBits[5-irk_pkg::FLIP_KEY_BASE-k];
      end
   end

   // ==========================================================================
   // toggle outputs
   always_comb
   begin
      flipNext = q.keys.flip ^ flipHit;
      if (DEP_TOGGLE)
      begin
         // a key that drives its own output high wins the pair; if both keys do, toggle output a wins
         if (flipHit[0] && flipNext[0])
         begin
            flipNext[1] = 1'b0;
         end
         else if (flipHit[1] && flipNext[1])
         begin
            flipNext[0] = 1'b0;
         end
      end
   end

   // ==========================================================================
   // frame check and output stage
   always_comb
   begin
      d = q;
      d.latch = 1'b0;
      d.strap1 = {matchStrapA, matchStrapB, matchStrapC};
      d.strap2 = q.strap1;
      d.tickCnt = tick ? '0 : q.tickCnt + 10'h001;
      if (tick)
      begin
         d.subMs = (q.subMs == irk_pkg::MS_LAST) ? '0 : q.subMs + 7'h01;
      end
      rxCode = {q.ovf[0], q.shreg[9], q.shreg[8]};
      fullMismatch = q.mismatch | (sym.value ^ q.ovf[1]);
      payload = {q.shreg[7:0], sym.value};

      if (sym.abort)
      begin
         // a broken second frame voids the pair
         if (q.state == irk_pkg::ST_SECOND && q.bitCnt != '0)
         begin
            d.state = irk_pkg::ST_FIRST;
         end
         d.bitCnt = '0;
      end
      else if (sym.valid)
      begin
         d.shreg = {q.shreg[8:0], sym.value};
         d.ovf = {q.ovf[0], q.shreg[9]};
         if (q.state == irk_pkg::ST_SECOND)
         begin
            d.mismatch = fullMismatch;
         end
         if (q.bitCnt == irk_pkg::FRAME_LAST)
         begin
            d.bitCnt = '0;
            if (q.state == irk_pkg::ST_FIRST)
            begin
               if (rxCode == expCode)
               begin
                  d.state = irk_pkg::ST_SECOND;
                  d.mismatch = 1'b0;
                  d.gapMs = '0;
               end
            end
            else
            begin
               d.state = irk_pkg::ST_FIRST;
               if (!fullMismatch)
               begin
                  d.latch = 1'b1;
                  d.data = payload;
               end
            end
         end
         else
         begin
            d.bitCnt = q.bitCnt + 4'h1;
         end
      end
      else if (q.state == irk_pkg::ST_SECOND && q.bitCnt == '0 && msTick)
      begin
         // second frame never came; start over with a fresh first frame
         if (q.gapMs == irk_pkg::PAIR_GAP_LAST)
         begin
            d.state = irk_pkg::ST_FIRST;
         end
         else
         begin
            d.gapMs = q.gapMs + 8'h01;
         end
      end

      // each held output restarts its release time at every accepted pair that carries its key, except held key six in the 16-pin variant
      for (int k = 0; k < irk_pkg::N_HELD; k++)
      begin
         if (heldHit[k])
         begin
            d.holdCnt[k] = irk_pkg::HOLD_LOAD;
         end
         else if (msTick && q.holdCnt[k] != '0)
         begin
            d.holdCnt[k] = q.holdCnt[k] - 8'h01;
         end
         d.keys.held[k] = (d.holdCnt[k] != '0);
      end

      // a running pulse is not stretched by a repeated key
      for (int k = 0; k < irk_pkg::N_PULSE; k++)
      begin
         if (pulseHit[k] && q.pulseCnt[k] == '0)
         begin
            d.pulseCnt[k] = irk_pkg::PULSE_LOAD;
         end
         else if (msTick && q.pulseCnt[k] != '0)
         begin
            d.pulseCnt[k] = q.pulseCnt[k] - 8'h01;
         end
         d.keys.pulse[k] = (d.pulseCnt[k] != '0);
      end

      d.keys.flip = flipNext;
      case (q.state)
         irk_pkg::ST_FIRST,
         irk_pkg::ST_SECOND:
         begin
         end
         default:
         begin
            d.state = irk_pkg::ST_FIRST;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         q <= '{state: irk_pkg::ST_FIRST, strap1: irk_pkg::SYNC_RST,
                strap2: irk_pkg::SYNC_RST, default: '0};
      end
      else
      begin
         q <= d;
      end
   end

   // ==========================================================================
   // outputs
   assign keys = q.keys;
   assign dataLatch = q.latch;
   assign latchedData = q.data;

endmodule

// >>> irk_key_decoder_props.sv
`timescale 1ns/10ps

module irk_key_decoder_props #(
   parameter int TICK_CYC = irk_pkg::TICK_CYC
) (
   input wire logic clk, // clock
   input wire logic arst_n, // reset
   input wire logic irSerialInput, // receiver line
   input wire logic matchStrapA, // strap a
   input wire logic matchStrapB, // strap b
   input wire logic matchStrapC, // strap c
   input irk_pkg::irk_keys_s keys, // key outputs
   input wire logic dataLatch, // latch pulse
   input wire logic [8:0] latchedData // latched bits
);
   // ======================================
   // interval counters; 1 ms enable phase makes them up to 1 ms short
   localparam int MS = irk_pkg::MS_TICKS * TICK_CYC;
   localparam int HOLD_MIN = (irk_pkg::HOLD_MS - 1) * MS;
   localparam int HOLD_MAX = irk_pkg::HOLD_MS * MS;
   localparam int PULSE_MIN = (irk_pkg::PULSE_MS - 1) * MS;
   localparam int PULSE_MAX = irk_pkg::PULSE_MS * MS;
   logic [24:0] pulseCnt_q;
   logic [24:0] holdCnt_q;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pulseCnt_q <= '0;
         holdCnt_q <= '0;
      end
      else
      begin
         pulseCnt_q <= keys.pulse[0] ? pulseCnt_q + 25'h1 : 25'h0;
         // only a latch of held key one restarts its release time
         holdCnt_q <= (dataLatch && latchedData[8] && latchedData[5]) ?
                      25'h0 : holdCnt_q + 25'h1;
      end
   end

   // ======================================
   // properties
   default clocking @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   sequence heldOneLatch;
      dataLatch && latchedData[8] && latchedData[5];
   endsequence
   sequence flipALatch;
      dataLatch && latchedData[6] && latchedData[1] && !latchedData[0];
   endsequence

   chk_latch_single:
   assert property (dataLatch |=> !dataLatch)
      else $error("latch pulse wider than one cycle");
   chk_data_hold:
   assert property (!dataLatch |-> $stable(latchedData))
      else $error("latched data moved without latch");
   chk_held_cause:
   assert property ((keys.held & ~$past(keys.held)) != '0 |->
      $past(dataLatch) && $past(latchedData[8]))
      else $error("held output rose without held group latch");
   chk_held_set:
   assert property (heldOneLatch |=> keys.held[0])
      else $error("held output one not raised");
   chk_held_time:
   assert property ($fell(keys.held[0]) |->
      holdCnt_q >= HOLD_MIN && holdCnt_q <= HOLD_MAX)
      else $error("held release interval wrong");
   chk_pulse_time:
   assert property ($fell(keys.pulse[0]) |->
      pulseCnt_q >= PULSE_MIN && pulseCnt_q <= PULSE_MAX)
      else $error("pulse width wrong");
   chk_flip_stable:
   assert property (!dataLatch |=> $stable(keys.flip))
      else $error("toggle output moved without latch");
   chk_flip_invert:
   assert property (flipALatch |=> keys.flip[0] != $past(keys.flip[0]))
      else $error("toggle output a did not invert");
endmodule

// >>> irk_key_decoder_tb.sv
`timescale 1ns/10ps

`define CHECK_EQ(got, exp) \
   begin \
      totalChecks++; \
      if ((got) !== (exp)) \
      begin \
         failCount++; \
         $display("wrong value at %0t: got %0h", $time, got); \
      end \
   end

module irk_key_decoder_tb;
   // one clock per tick keeps the long hold and pulse times affordable
   localparam int TICK_CYC = 1;
   logic clk;
   logic arst_n;
   logic strapA;
   logic strapB;
   logic strapC;
   logic irLine;
   irk_pkg::irk_keys_s keys1;
   irk_pkg::irk_keys_s keys2;
   logic latch1;
   logic latch2;
   logic [8:0] data1;
   logic [8:0] data2;
   int n1;
   int n2;
   int failCount;
   int totalChecks;

   irk_ir_tx #(.TICK_CYC(TICK_CYC)) TX (.clk(clk), .line(irLine));
   irk_key_decoder #(.TICK_CYC(TICK_CYC)) DUT (.clk(clk), .arst_n(arst_n),
      .irSerialInput(irLine),
      .matchStrapA(strapA), .matchStrapB(strapB), .matchStrapC(strapC),
      .keys(keys1), .dataLatch(latch1), .latchedData(data1));
   // 16-pin, inverted line, dependent toggles
   irk_key_decoder #(.PINS24(1'b0), .INV_INPUT(1'b1), .DEP_TOGGLE(1'b1),
      .TICK_CYC(TICK_CYC)) DUT2
      (.clk(clk), .arst_n(arst_n), .irSerialInput(!irLine),
      .matchStrapA(strapA), .matchStrapB(strapB), .matchStrapC(strapC),
      .keys(keys2), .dataLatch(latch2), .latchedData(data2));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk)
   begin
      if (latch1 === 1'b1)
         n1++;
      if (latch2 === 1'b1)
         n2++;
   end

   task automatic finalReport();
      if (failCount == 0 && totalChecks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic wait_ms(input int ms);
      repeat (ms * irk_pkg::MS_TICKS * TICK_CYC) @(negedge clk);
   endtask

   // ======================================
   // scenarios
   task automatic t_held();
      TX.send_pair({3'h5, 3'h4, 6'h20});
      `CHECK_EQ(n1, 1)
      `CHECK_EQ(data1, 9'h120)
      `CHECK_EQ(keys1.held, 6'h01)
      `CHECK_EQ(keys2.held, 6'h01)
      TX.send_pair({3'h5, 3'h4, 6'h20});
      `CHECK_EQ(n1, 2)
      wait_ms(150);
      `CHECK_EQ(keys1.held, 6'h01)
      wait_ms(11);
      `CHECK_EQ(keys1.held, 6'h00)
      `CHECK_EQ(keys2.held, 6'h00)
   endtask

   task automatic t_multi();
      TX.send_pair({3'h5, 3'h2, 6'h3f});
      `CHECK_EQ(keys1.pulse, 10'h03f)
      `CHECK_EQ(keys2.pulse, 10'h01f)
      wait_ms(108);
      `CHECK_EQ(keys1.pulse, 10'h000)
   endtask

   task automatic t_third();
      TX.send_pair({3'h5, 3'h1, 6'h3e});
      `CHECK_EQ(keys1.pulse, 10'h3c0)
      `CHECK_EQ(keys1.flip, 2'h1)
      `CHECK_EQ(keys2.flip, 2'h1)
      TX.send_pair({3'h5, 3'h1, 6'h01});
      `CHECK_EQ(keys1.flip, 2'h3)
      `CHECK_EQ(keys2.flip, 2'h2)
      TX.send_pair({3'h5, 3'h1, 6'h02});
      `CHECK_EQ(keys1.flip, 2'h2)
      `CHECK_EQ(keys2.flip, 2'h1)
   endtask

   task automatic t_code();
      int a;
      int b;
      strapA = 1'b0;
      wait_ms(1);
      a = n1;
      b = n2;
      TX.send_pair({3'h5, 3'h4, 6'h10});
      `CHECK_EQ(n1, a)
      `CHECK_EQ(n2, b + 1)
      TX.send_pair({3'h1, 3'h4, 6'h10});
      `CHECK_EQ(n1, a + 1)
      `CHECK_EQ(n2, b + 1)
      strapA = 1'b1;
      strapC = 1'b0;
      wait_ms(1);
      TX.send_pair({3'h4, 3'h4, 6'h10});
      `CHECK_EQ(n1, a + 1)
      `CHECK_EQ(n2, b + 2)
      strapC = 1'b1;
      wait_ms(1);
   endtask

   task automatic t_diff();
      int a;
      a = n1;
      TX.send_frame({3'h5, 3'h4, 6'h10});
      TX.send_frame({3'h5, 3'h4, 6'h18});
      `CHECK_EQ(n1, a)
      TX.send_pair({3'h5, 3'h4, 6'h08});
      `CHECK_EQ(n1, a + 1)
      `CHECK_EQ(data1, 9'h108)
   endtask

   initial
   begin
      arst_n = 1'b0;
      strapA = 1'b1;
      strapB = 1'b0;
      strapC = 1'b1;
      repeat (12) @(negedge clk);
      `CHECK_EQ(keys1, '0)
      arst_n = 1'b1;
      t_held();
      t_multi();
      t_third();
      t_code();
      t_diff();
      finalReport();
   end

   initial
   begin
      repeat (90000) @(posedge clk);
      failCount++;
      finalReport();
   end
endmodule

bind irk_key_decoder irk_key_decoder_props #(.TICK_CYC(TICK_CYC))
   u_props (.clk(clk),
   .arst_n(arst_n), .irSerialInput(irSerialInput),
   .matchStrapA(matchStrapA), .matchStrapB(matchStrapB),
   .matchStrapC(matchStrapC), .keys(keys), .dataLatch(dataLatch),
   .latchedData(latchedData));

// >>> irk_pkg.sv
package irk_pkg;

   // ==========================================================================
   // clocking and time base
   localparam int CLK_MHZ = 100;
   localparam int TICK_US = 10;
   localparam int TICK_CYC = TICK_US * CLK_MHZ;
   localparam logic [9:0] TICK_LAST = 10'(TICK_CYC - 1);
   localparam int MS_TICKS = 1000 / TICK_US;
   localparam logic [6:0] MS_LAST = 7'(MS_TICKS - 1);

   // ==========================================================================
   // output timing, in milliseconds
   localparam int HOLD_MS = 160;
   localparam int PULSE_MS = 107;
   localparam int PAIR_GAP_MS = 200;
   localparam logic [7:0] HOLD_LOAD = 8'(HOLD_MS);
   localparam logic [7:0] PULSE_LOAD = 8'(PULSE_MS);
   localparam logic [7:0] PAIR_GAP_LAST = 8'(PAIR_GAP_MS - 1);

   // ==========================================================================
   // bit symbol timing on the receiver input, in microseconds
   localparam int GLITCH_US = 20;
   localparam int ONE_MIN_US = 600;
   localparam int GAP_US = 2000;
   localparam logic [7:0] GLITCH_TICKS = 8'((GLITCH_US + TICK_US - 1) / TICK_US);
   localparam logic [7:0] ONE_MIN_TICKS = 8'((ONE_MIN_US + TICK_US - 1) / TICK_US);
   localparam logic [7:0] GAP_LAST = 8'((GAP_US + TICK_US - 1) / TICK_US - 1);

   // ==========================================================================
   // frame layout
   localparam int FRAME_BITS = 12;
   localparam int SHIFT_BITS = 10;
   localparam int CODE_BITS = 3;
   localparam int DATA_BITS = 9;
   localparam logic [3:0] FRAME_LAST = 4'(FRAME_BITS - 1);
   localparam int GRP_FIRST_POS = 8;
   localparam int GRP_SECOND_POS = 7;
   localparam int GRP_THIRD_POS = 6;
   localparam int KEY_FIRST_POS = 5;

   // ==========================================================================
   // output population
   localparam int N_HELD = 6;
   localparam int N_PULSE = 10;
   localparam int N_FLIP = 2;
   localparam int PULSE_GRP3_BASE = 6;
   localparam int PULSE_GRP3_KEYS = 4;
   localparam int FLIP_KEY_BASE = 4;
   localparam logic [N_HELD-1:0] HELD_MASK16 = 6'h1f;
   localparam logic [N_PULSE-1:0] PULSE_MASK16 = 10'h01f;
   localparam logic [2:0] SYNC_RST = 3'h7;

   // ==========================================================================
   // types
   typedef enum logic [0:0] {ST_FIRST, ST_SECOND} irk_frame_e;

   typedef struct packed {
      logic valid;
      logic value;
      logic abort;
   } irk_sym_s;

   typedef struct packed {
      logic [N_HELD-1:0] held;
      logic [N_PULSE-1:0] pulse;
      logic [N_FLIP-1:0] flip;
   } irk_keys_s;

endpackage
